// ==== common/threshold_monitor_pkg.sv ====
`default_nettype none
package threshold_monitor_pkg;
    localparam int THR_W = 8;
    localparam int SEL_W = 3;
    localparam int PRE_W = 5;
    localparam int ADDR_W = 8;
    localparam int STAT_W = 3;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL_A = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_HW_CONFIG = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_EVENTS = 8'h18;

    // field positions
    localparam int START_SEL_LSB = 0;
    localparam int END_SEL_LSB = 4;
    localparam int THR_LSB = 0;
    localparam int SCALE_BIT = 13;
    localparam int RUNNING_BIT = 16;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_END = 1;
    localparam int ST_ORDER = 2;

    // reset values
    localparam logic [SEL_W-1:0] START_SEL_RST = 3'h0;
    localparam logic [SEL_W-1:0] END_SEL_RST = 3'h0;
    localparam logic [THR_W-1:0] THR_RST = 8'h00;
    localparam logic SCALE_RST = 1'b0;
    localparam logic [STAT_W-1:0] MASK_RST = 3'h0;

    // event select codes, shared by start and end fields
    localparam logic [SEL_W-1:0] SEL_DECODE = 3'h1;
    localparam logic [SEL_W-1:0] SEL_DISPATCH = 3'h2;
    localparam logic [SEL_W-1:0] SEL_ISSUE = 3'h3;
    localparam logic [SEL_W-1:0] SEL_FINISH = 3'h4;
    localparam logic [SEL_W-1:0] SEL_COMPLETE = 3'h5;
    localparam logic [SEL_W-1:0] SEL_NONE = 3'h0;

    // slow scaling: one decrement per 32 cycles
    localparam logic [PRE_W-1:0] PRESCALE_LAST = 5'h1F;

    typedef enum logic [1:0] {
        TMR_IDLE = 2'b01,
        TMR_RUN = 2'b10
    } timer_state_t;

    // one-cycle stage pulses of the marked instruction
    typedef struct packed {
        logic complete;
        logic finish;
        logic issue;
        logic dispatch;
        logic decode;
    } stage_events_t;

    function automatic logic event_hit(
        input logic [SEL_W-1:0] sel,
        input stage_events_t ev,
        input logic is_end
    );
        case (sel)
            SEL_DECODE: event_hit = !is_end && ev.decode;
            SEL_DISPATCH: event_hit = ev.dispatch;
            SEL_ISSUE: event_hit = ev.issue;
            SEL_FINISH: event_hit = ev.finish;
            SEL_COMPLETE: event_hit = ev.complete;
            default: event_hit = 1'b0;
        endcase
    endfunction : event_hit

    function automatic logic sel_valid(input logic [SEL_W-1:0] sel, input logic is_end);
        sel_valid = (sel >= (is_end ? SEL_DISPATCH : SEL_DECODE)) && (sel <= SEL_COMPLETE);
    endfunction : sel_valid
endpackage : threshold_monitor_pkg
`default_nettype wire

// ==== design/threshold_timer.sv ====
`default_nettype none
module threshold_timer
    import threshold_monitor_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic scale_in,
    input wire logic [THR_W-1:0] threshold_in,
    output logic [THR_W-1:0] count_out,
    output logic running_out,
    output logic tick_out,
    output logic timeout_out
);
    timer_state_t state;
    logic [PRE_W-1:0] prescale;

    assign running_out = (state == TMR_RUN);
    assign tick_out = running_out && (!scale_in || prescale == PRESCALE_LAST);
    // an end event in the same cycle wins over the time-out
    assign timeout_out = tick_out && (count_out <= THR_W'(1)) && !stop_in;

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= TMR_IDLE;
            count_out <= THR_RST;
            prescale <= '0;
        end
        else
        begin
            case (state)
                TMR_IDLE:
                begin
                    // idle keeps tracking the programmed value
                    count_out <= threshold_in;
                    prescale <= '0;
                    if (start_in)
                    begin
                        state <= TMR_RUN;
                    end
                end
                TMR_RUN:
                begin
                    if (stop_in || timeout_out)
                    begin
                        state <= TMR_IDLE;
                        count_out <= threshold_in;
                    end
                    else if (tick_out)
                    begin
                        count_out <= count_out - THR_W'(1);
                    end
                    prescale <= prescale + PRE_W'(1);
                end
                default:
                begin
                    state <= TMR_IDLE;
                end
            endcase
        end
    end
endmodule : threshold_timer
`default_nettype wire

// ==== design/pipeline_threshold_monitor.sv ====
// Contract
// - one marked instruction tracked at a time against a single threshold.
// - down-counter starts from the software threshold count value field.
// - scale bit 13 clear: decrement every processor clock cycle.
// - scale bit set: decrement once per 32 processor clock cycles.
// - stages come in order decode, dispatch, issue, finish, complete.
// - after the start event count down until time-out or end event.
// - time-out emits a threshold event and bumps the event counter.
// - time-out and end event both reload the threshold value.
// - after reload stay idle until the next selected start event.
// - start codes 1..5 select decode..complete; others select nothing.
// - end codes 2..5 select dispatch..complete; others select nothing.
// - finish means rename registers updated; complete means architected update.
`default_nettype none
module pipeline_threshold_monitor
    import threshold_monitor_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire stage_events_t stage_events_in,
    output logic threshold_event_out,
    output logic irq_out
);
    logic [SEL_W-1:0] start_sel;
    logic [SEL_W-1:0] end_sel;
    logic [THR_W-1:0] threshold_count_value;
    logic scale;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic [31:0] event_count;
    logic [SEL_W-1:0] last_stage;
    logic [STAT_W-1:0] next_status;
    logic [STAT_W-1:0] status_set;
    logic [SEL_W-1:0] stage_code;
    logic order_bad;
    logic sel_ok;
    logic start_go;
    logic end_go;
    logic stop_go;
    logic running;
    logic tick;
    logic timeout;
    logic [THR_W-1:0] count;
    logic access;
    logic wr_fire;
    logic addr_ok;
    logic [31:0] rd_mux;

    // bus side

    // access phase is answered one cycle late so every output stays a flop
    assign access = psel_in && penable_in && !pready_out;
    assign wr_fire = psel_in && penable_in && pready_out && pwrite_in;

    always_comb
    begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr_in)
            OFS_CONTROL_A:
            begin
                rd_mux[START_SEL_LSB +: SEL_W] = start_sel;
                rd_mux[END_SEL_LSB +: SEL_W] = end_sel;
            end
            OFS_CONTROL_ONE: rd_mux[THR_LSB +: THR_W] = threshold_count_value;
            OFS_HW_CONFIG: rd_mux[SCALE_BIT] = scale;
            OFS_STATUS: rd_mux[STAT_W-1:0] = status;
            OFS_MASK: rd_mux[STAT_W-1:0] = mask;
            OFS_COUNT:
            begin
                rd_mux[THR_W-1:0] = count;
                rd_mux[RUNNING_BIT] = running;
            end
            OFS_EVENTS: rd_mux = event_count;
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end
        else
        begin
            pready_out <= access;
            pslverr_out <= access && !addr_ok;
            if (access)
            begin
                prdata_out <= (pwrite_in || !addr_ok) ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // control registers
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            start_sel <= START_SEL_RST;
            end_sel <= END_SEL_RST;
            threshold_count_value <= THR_RST;
            scale <= SCALE_RST;
            mask <= MASK_RST;
        end
        else if (wr_fire)
        begin
            case (paddr_in)
                OFS_CONTROL_A:
                begin
                    start_sel <= pwdata_in[START_SEL_LSB +: SEL_W];
                    end_sel <= pwdata_in[END_SEL_LSB +: SEL_W];
                end
                OFS_CONTROL_ONE: threshold_count_value <= pwdata_in[THR_LSB +: THR_W];
                OFS_HW_CONFIG: scale <= pwdata_in[SCALE_BIT];
                OFS_MASK: mask <= pwdata_in[STAT_W-1:0];
                default: ;
            endcase
        end
    end

    // event selection

    // finish is the rename update, complete the architected update
    assign sel_ok = sel_valid(start_sel, 1'b0) && sel_valid(end_sel, 1'b1);
    // a start seen while one instruction is already timed is dropped
    assign start_go = sel_ok && !running && event_hit(start_sel, stage_events_in, 1'b0);
    assign end_go = sel_ok && running && event_hit(end_sel, stage_events_in, 1'b1);
    // clearing a select mid-run drops the instruction, so no late threshold event escapes
    assign stop_go = end_go || !sel_ok;

    threshold_timer u_timer (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .start_in(start_go),
        .stop_in(stop_go),
        .scale_in(scale),
        .threshold_in(threshold_count_value),
        .count_out(count),
        .running_out(running),
        .tick_out(tick),
        .timeout_out(timeout)
    );

    // stage order watch: highest stage wins if several pulse together
    always_comb
    begin
        stage_code = SEL_NONE;
        if (stage_events_in.complete)
        begin
            stage_code = SEL_COMPLETE;
        end
        else if (stage_events_in.finish)
        begin
            stage_code = SEL_FINISH;
        end
        else if (stage_events_in.issue)
        begin
            stage_code = SEL_ISSUE;
        end
        else if (stage_events_in.dispatch)
        begin
            stage_code = SEL_DISPATCH;
        end
        else if (stage_events_in.decode)
        begin
            stage_code = SEL_DECODE;
        end
    end

    assign order_bad = (stage_code > SEL_DECODE) && (last_stage != stage_code - SEL_W'(1));

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            last_stage <= SEL_NONE;
        end
        else if (stage_code != SEL_NONE)
        begin
            last_stage <= stage_code;
        end
    end

    // threshold event and its counter
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            threshold_event_out <= 1'b0;
            event_count <= 32'h0000_0000;
        end
        else
        begin
            threshold_event_out <= timeout;
            if (timeout)
            begin
                event_count <= event_count + 32'h0000_0001;
            end
        end
    end

    // interrupt status: set wins over a write-one clear
    always_comb
    begin
        status_set = '0;
        status_set[ST_TIMEOUT] = timeout;
        status_set[ST_END] = end_go;
        status_set[ST_ORDER] = order_bad;
        next_status = status;
        if (wr_fire && paddr_in == OFS_STATUS)
        begin
            next_status = status & ~pwdata_in[STAT_W-1:0];
        end
        next_status = next_status | status_set;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            status <= '0;
            irq_out <= 1'b0;
        end
        else
        begin
            status <= next_status;
            irq_out <= |(next_status & mask);
        end
    end

    // checking helpers
    logic [5:0] gap;
    logic slow_run;

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            gap <= '0;
            slow_run <= 1'b0;
        end
        else
        begin
            if (!running || tick)
            begin
                gap <= '0;
            end
            else if (gap != 6'h3F)
            begin
                gap <= gap + 6'h01;
            end
            if (!running)
            begin
                slow_run <= 1'b1;
            end
            else if (!scale)
            begin
                slow_run <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_start_taken;
        !running && start_go;
    endsequence

    sequence s_end_taken;
        running && end_go;
    endsequence

    sequence s_idle_reloaded;
        !running && count == $past(threshold_count_value);
    endsequence

    sequence s_loaded;
        count == $past(threshold_count_value);
    endsequence

    sequence s_timed_out;
        running && timeout;
    endsequence

    sequence s_still_timing;
        running && !stop_go && !timeout;
    endsequence

    a_start_runs: assert property (s_start_taken |=> running)
        else $error("start event did not start the counter");
    a_end_reloads: assert property (s_end_taken |=> s_idle_reloaded)
        else $error("end event did not reload and idle");
    a_timeout_reload: assert property (timeout |=> s_idle_reloaded ##0 threshold_event_out)
        else $error("time-out did not pulse and reload");
    a_event_counts: assert property (timeout |=> event_count == $past(event_count) + 32'h1)
        else $error("event counter did not step by one");
    a_no_select_idle: assert property (!sel_ok [*2] |-> !running && !timeout)
        else $error("counter ran with a no-event select");
    a_fast_tick: assert property (running && !scale |-> tick)
        else $error("unscaled counter skipped a cycle");
    a_slow_gap: assert property (tick && scale && slow_run |-> gap == 6'd31)
        else $error("scaled tick not every 32 cycles");
    a_count_step: assert property (running && tick && !stop_go && count > 8'h1
        |=> count == $past(count) - 8'h1)
        else $error("count did not decrement by one");
    a_idle_waits: assert property (!running && !start_go |=> !running)
        else $error("counter left idle without a start");
    a_single_track: assert property (s_still_timing |=> running && !start_go)
        else $error("second start accepted while timing");
    a_start_reload: assert property (s_start_taken |=> s_loaded)
        else $error("start did not begin from the threshold value");
    a_event_single: assert property (threshold_event_out |=> !threshold_event_out)
        else $error("threshold event longer than one cycle");
    a_timeout_status: assert property (s_timed_out |=> status[ST_TIMEOUT])
        else $error("time-out not recorded in status");
    a_end_status: assert property (s_end_taken |=> status[ST_END])
        else $error("end event not recorded in status");
    a_bad_sel_quiet: assert property (!sel_ok |-> !start_go && !end_go)
        else $error("no-event select produced a start or end");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    a_slverr_ready: assert property (pslverr_out |-> pready_out)
        else $error("error response without ready");
    a_order_flag: assert property (order_bad |=> status[ST_ORDER])
        else $error("out-of-order stage not flagged");
    a_irq_level: assert property (##1 irq_out == |$past(next_status & mask))
        else $error("interrupt level wrong");
endmodule : pipeline_threshold_monitor
`default_nettype wire

// ==== dv/pipeline_stage_model.sv ====
`default_nettype none
module pipeline_stage_model
    import threshold_monitor_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic launch_in,
    input wire logic [7:0] gap_in,
    input wire logic skip_in,
    output stage_events_t stage_events_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] stage;
    logic [7:0] wait_cnt;

    // only one marked instruction in flight; a launch while busy is dropped
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stage_events_out <= '0;
            busy_out <= 1'b0;
            stage <= 3'h0;
            wait_cnt <= 8'h00;
        end
        else
        begin
            stage_events_out <= '0;
            if (!busy_out)
            begin
                if (launch_in)
                begin
                    stage_events_out <= stage_events_t'(5'h01);
                    busy_out <= 1'b1;
                    // a skip drops dispatch so the order watch can be exercised
                    stage <= skip_in ? 3'h2 : 3'h1;
                    wait_cnt <= gap_in;
                end
            end
            else if (wait_cnt != 8'h00)
                wait_cnt <= wait_cnt - 8'h01;
            else if (stage == 3'h5)
                busy_out <= 1'b0;
            else
            begin
                // stages strictly in pipeline order, one-cycle pulses
                stage_events_out <= stage_events_t'(5'h01 << stage);
                stage <= stage + 3'h1;
                wait_cnt <= gap_in;
            end
        end
    end
endmodule : pipeline_stage_model
`default_nettype wire

// ==== dv/tb_pipeline_threshold_monitor.sv ====
`default_nettype none
module tb_pipeline_threshold_monitor import threshold_monitor_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, thr_event, irq, launch, busy, skip;
    logic [7:0] paddr, gap;
    logic [31:0] pwdata, prdata;
    stage_events_t stage_ev;
    int fail_count = 0;
    int num_checks = 0;
    int exp_events = 0;

    pipeline_threshold_monitor i_dut (.sys_clk_in(clk), .rst_in(rst), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .stage_events_in(stage_ev), .threshold_event_out(thr_event), .irq_out(irq));
    pipeline_stage_model i_pipe (.sys_clk_in(clk), .rst_in(rst), .launch_in(launch),
        .gap_in(gap), .skip_in(skip), .stage_events_out(stage_ev), .busy_out(busy));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            fail_count++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(name, exp, r);
    endtask : rd_chk

    task automatic cfg(input logic [2:0] s, input logic [2:0] e, input logic [7:0] t,
        input logic sc);
        wr(OFS_CONTROL_A, {25'h0, e, 1'b0, s});
        wr(OFS_CONTROL_ONE, {24'h0, t});
        wr(OFS_HW_CONFIG, {18'h0, sc, 13'h0});
        wr(OFS_STATUS, 32'h7);
    endtask : cfg

    // launch one marked instruction and watch the selected start stage and events
    task automatic run(input int s, input logic [7:0] g, output int dly, output int n_ev);
        int t0;
        t0 = -1;
        dly = -1;
        n_ev = 0;
        gap <= g;
        launch <= 1'b1;
        @(posedge clk);
        launch <= 1'b0;
        for (int i = 0; i < 5 * (g + 1) + 40; i++)
        begin
            @(posedge clk);
            if (s inside {[1:5]} && stage_ev[s-1] === 1'b1 && t0 < 0)
                t0 = i;
            if (thr_event === 1'b1)
            begin
                n_ev++;
                dly = i - t0;
            end
        end
        check("pipeline drained", 0, {31'h0, busy});
    endtask : run

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 7; i++)
            rd_chk("reset value", 8'(4 * i), 32'h0);
        apb(1'b0, 8'h1C, 32'h0, r, e);
        check("unmapped error", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, r);
        wr(OFS_EVENTS, 32'hFFFF_FFFF);
        wr(OFS_COUNT, 32'hFFFF_FFFF);
        rd_chk("events read only", OFS_EVENTS, 32'h0);
        rd_chk("count read only", OFS_COUNT, 32'h0);
    endtask : t_regs

    task automatic t_timeout(input logic [7:0] t, input logic sc);
        int d, n, ticks;
        ticks = (t == 8'h00) ? 1 : int'(t);
        cfg(SEL_DECODE, SEL_COMPLETE, t, sc);
        wr(OFS_MASK, 32'h1);
        run(1, 8'd40, d, n);
        exp_events++;
        check("timeout delay", ticks * (sc ? 32 : 1) + 1, d);
        check("event pulses", 1, n);
        rd_chk("event count", OFS_EVENTS, exp_events);
        rd_chk("reloaded idle", OFS_COUNT, {24'h0, t});
        rd_chk("status timeout", OFS_STATUS, 32'h1);
        check("irq raised", 1, {31'h0, irq});
        wr(OFS_MASK, 32'h0);
        repeat (2) @(posedge clk);
        check("irq masked", 0, {31'h0, irq});
        wr(OFS_STATUS, 32'h1);
        rd_chk("status cleared", OFS_STATUS, 32'h0);
    endtask : t_timeout

    task automatic t_end_codes();
        int d, n;
        for (int e = 2; e <= 5; e++)
        begin
            cfg(SEL_DECODE, 3'(e), 8'd100, 1'b0);
            run(1, 8'd2, d, n);
            check("end stops count", 0, n);
            rd_chk("status end", OFS_STATUS, 32'h2);
            rd_chk("end reload", OFS_COUNT, 32'd100);
        end
    endtask : t_end_codes

    task automatic t_start_codes();
        int d, n;
        for (int s = 1; s <= 4; s++)
        begin
            cfg(3'(s), SEL_COMPLETE, 8'd1, 1'b0);
            run(s, 8'd5, d, n);
            exp_events++;
            check("start code delay", 2, d);
            check("start code events", 1, n);
        end
        rd_chk("event total", OFS_EVENTS, exp_events);
    endtask : t_start_codes

    task automatic t_no_event();
        logic [2:0] st [7] = '{3'h0, 3'h6, 3'h7, 3'h1, 3'h1, 3'h1, 3'h1};
        logic [2:0] en [7] = '{3'h5, 3'h5, 3'h5, 3'h0, 3'h1, 3'h6, 3'h7};
        int d, n;
        for (int i = 0; i < 7; i++)
        begin
            cfg(st[i], en[i], 8'd1, 1'b0);
            run(1, 8'd3, d, n);
            check("no event code", 0, n);
            rd_chk("never running", OFS_COUNT, 32'h1);
        end
        // a select cleared while timing must stop the count and reload it
        cfg(SEL_DECODE, SEL_COMPLETE, 8'd100, 1'b0);
        launch <= 1'b1;
        @(posedge clk);
        launch <= 1'b0;
        repeat (3) @(posedge clk);
        wr(OFS_CONTROL_A, 32'h0);
        rd_chk("select cleared mid-run", OFS_COUNT, 32'd100);
        repeat (40) @(posedge clk);
        rd_chk("no event after clear", OFS_EVENTS, exp_events);
    endtask : t_no_event

    task automatic t_order();
        int d, n;
        cfg(SEL_NONE, SEL_NONE, 8'd1, 1'b0);
        wr(OFS_MASK, 32'h4);
        skip <= 1'b1;
        run(1, 8'd1, d, n);
        skip <= 1'b0;
        rd_chk("status order", OFS_STATUS, 32'h4);
        check("order irq", 1, {31'h0, irq});
        wr(OFS_MASK, 32'h0);
        wr(OFS_STATUS, 32'h4);
        rd_chk("order cleared", OFS_STATUS, 32'h0);
    endtask : t_order

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        launch = 1'b0;
        gap = 8'h00;
        skip = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_timeout(8'd2, 1'b0);
        t_timeout(8'd0, 1'b0);
        t_timeout(8'd2, 1'b1);
        t_end_codes();
        t_start_codes();
        t_no_event();
        t_order();
        test_done();
    end
endmodule : tb_pipeline_threshold_monitor
`default_nettype wire
